// ---- logic/rxai_top.sv ----
`timescale 1ns/1ps
`include "rxai_consts.svh"
module rxai_top
  import rxai_pkg::*;
(
  input wire logic ref_clk,                 // 20 MHz clock
  input wire logic reset_n,                 // Synchronous reset, low
  input wire logic psel,                    // APB select
  input wire logic penable,                 // APB enable
  input wire logic pwrite,                  // APB direction
  input wire logic [7:0] paddr,             // APB byte address
  input wire logic [31:0] pwdata,           // APB write data
  output logic [31:0] prdata,               // APB read data
  output logic pready,                      // APB ready
  output logic pslverr,                     // APB error
  input wire rxai_det_s det_in,             // Asynchronous detector levels
  input wire logic fifo_self_recover,       // FIFO auto reset on
  input wire logic pattern_checker_enabled, // Checker enabled
  output rxai_ctl_s ctl_out,                // Receiver controls
  output logic irq_out                      // Interrupt, high
);

  // Address decode shared by read and write paths
  function automatic logic rxai_hit(input logic [7:0] a, input logic [5:0] idx);
    rxai_hit = (a[1:0] == 2'h0) && (a[7:2] == idx);
  endfunction

  rxai_state_s st;      // Registered state
  rxai_state_s nxt_st;  // Next state

  // Zero-wait slave, data and error from flops
  assign pready = 1'b1;
  assign prdata = st.prdata;
  assign pslverr = st.pslverr;
  assign ctl_out = st.ctl;
  assign irq_out = st.irq;

  // Next-state logic
  always_comb begin
    logic setup;
    logic wr;
    logic mapped;
    logic cal_done_rise;
    logic fifo_rise;
    logic digital_signal_loss;
    logic los;
    logic ltr_act;
    logic use_q;
    logic ref_ok;
    logic [6:0] keep;
    logic [7:0] rd;
    setup = 1'b0;
    wr = 1'b0;
    mapped = 1'b0;
    cal_done_rise = 1'b0;
    fifo_rise = 1'b0;
    digital_signal_loss = 1'b0;
    los = 1'b0;
    ltr_act = 1'b0;
    use_q = 1'b0;
    ref_ok = 1'b0;
    keep = 7'h7f;
    rd = 8'h00;
    nxt_st = st;

    // Three-stage input capture; a change counts when stages two and three agree
    nxt_st.s1 = det_in;
    nxt_st.s2 = st.s1;
    nxt_st.s3 = st.s2;
    nxt_st.filt = (st.s2 & st.s3) | (st.filt & (st.s2 ^ st.s3));
    cal_done_rise = nxt_st.filt.cal_done & ~st.filt.cal_done;
    fifo_rise = nxt_st.filt.fifo_fault & ~st.filt.fifo_fault;

    // Bus phases
    setup = psel & ~penable;
    wr = psel & penable & pwrite;
    mapped = rxai_hit(paddr, `RXAI_IDX_CHIP) | rxai_hit(paddr, `RXAI_IDX_MASK)
           | rxai_hit(paddr, `RXAI_IDX_STICKY) | rxai_hit(paddr, `RXAI_IDX_CMU)
           | rxai_hit(paddr, `RXAI_IDX_LOCK) | rxai_hit(paddr, `RXAI_IDX_CAL)
           | rxai_hit(paddr, `RXAI_IDX_ALARM) | rxai_hit(paddr, `RXAI_IDX_LOSC);

    // Calibration completes on the done edge
    nxt_st.ctl.recal_start = 1'b0;
    if (st.cal == RXAI_CAL_BUSY && cal_done_rise) begin
      nxt_st.cal = RXAI_CAL_IDLE;
    end

    // Register writes
    if (wr && mapped) begin
      if (rxai_hit(paddr, `RXAI_IDX_CHIP)) begin
        nxt_st.gie = pwdata[`RXAI_GIE_BIT];
      end
      if (rxai_hit(paddr, `RXAI_IDX_MASK)) begin
        nxt_st.mask = pwdata[6:0];
      end
      if (rxai_hit(paddr, `RXAI_IDX_STICKY)) begin
        keep = pwdata[6:0];
      end
      if (rxai_hit(paddr, `RXAI_IDX_CMU)) begin
        // Bit 3 stays zero; low bits kept as written
        nxt_st.cmu = {pwdata[7:4], 1'b0, pwdata[2:0]};
      end
      if (rxai_hit(paddr, `RXAI_IDX_LOCK)) begin
        nxt_st.lock = pwdata[6:0];
      end
      if (rxai_hit(paddr, `RXAI_IDX_CAL)) begin
        nxt_st.vco = pwdata[2:1];
        // Start only from idle; writing zero does not abort
        if (pwdata[`RXAI_CAL_RECAL] && st.cal == RXAI_CAL_IDLE) begin
          nxt_st.cal = RXAI_CAL_BUSY;
          nxt_st.ctl.recal_start = 1'b1;
        end
        if (pwdata[`RXAI_CAL_SWRST]) begin
          nxt_st.sw_rst = 1'b1;
        end
      end
      if (rxai_hit(paddr, `RXAI_IDX_LOSC)) begin
        nxt_st.losc = pwdata[3:0];
      end
    end

    // Soft reset restores receive registers one cycle after it is set
    if (st.sw_rst) begin
      nxt_st.mask = `RXAI_RST_MASK;
      nxt_st.sticky = 7'h00;
      nxt_st.cmu = `RXAI_RST_CMU;
      nxt_st.lock = `RXAI_RST_LOCK;
      nxt_st.vco = `RXAI_RST_VCO;
      nxt_st.losc = `RXAI_RST_LOSC;
      nxt_st.cal = RXAI_CAL_IDLE;
      nxt_st.sw_rst = 1'b0;
      keep = 7'h00;
    end

    // Sticky bits: a new alarm wins over a write of zero
    nxt_st.sticky = (st.sticky & keep) | st.alarm;
    if (!nxt_st.gie) begin
      nxt_st.sticky = 7'h00;
    end

    // Loss of signal from gated detections
    digital_signal_loss = (nxt_st.losc[`RXAI_LC_ZEROS] & nxt_st.filt.run_zeros)
         | (nxt_st.losc[`RXAI_LC_ONES] & nxt_st.filt.run_ones);
    los = (nxt_st.losc[`RXAI_LC_ANALOG_EN] & nxt_st.filt.analog_loss)
        | digital_signal_loss
        | (nxt_st.losc[`RXAI_LC_QUAL_EN] & nxt_st.filt.quality_loss);

    // Lock-to-reference and unlock mode
    ltr_act = nxt_st.lock[`RXAI_LK_CMU_REF]
            | (nxt_st.lock[`RXAI_LK_REF_ON_LOS] & los);
    if (nxt_st.lock[`RXAI_LK_MODE_OVR]) begin
      use_q = nxt_st.lock[`RXAI_LK_MODE_SEL];
    end else begin
      use_q = ~ltr_act;
    end

    // Live alarm vector
    nxt_st.alarm[6] = nxt_st.filt.ref_missing;
    nxt_st.alarm[5] = los;
    nxt_st.alarm[4] = (use_q ? nxt_st.filt.sqm_unlock : nxt_st.filt.freq_unlock)
                    | (nxt_st.lock[`RXAI_LK_UNLOCK_ON_LOS] & los)
                    | (nxt_st.vco == `RXAI_VCO_BAD);
    // With auto reset the fault shows for one cycle only
    nxt_st.alarm[3] = fifo_self_recover ? fifo_rise : nxt_st.filt.fifo_fault;
    nxt_st.alarm[2] = nxt_st.filt.pat_err_limit;
    nxt_st.alarm[1] = pattern_checker_enabled & nxt_st.filt.pat_unsynced;
    nxt_st.alarm[0] = nxt_st.filt.sqm_alarm;

    // VCO calibration mode decode
    ref_ok = ~nxt_st.filt.ref_missing & nxt_st.lock[`RXAI_LK_REF_PRESENT];
    case (nxt_st.vco)
      `RXAI_VCO_AUTO: begin
        nxt_st.ctl.vco_center_on_ref = ref_ok;
        nxt_st.ctl.vco_full_sweep = ~ref_ok;
      end
      `RXAI_VCO_NOREF: begin
        nxt_st.ctl.vco_center_on_ref = 1'b0;
        nxt_st.ctl.vco_full_sweep = 1'b1;
      end
      `RXAI_VCO_REF: begin
        nxt_st.ctl.vco_center_on_ref = 1'b1;
        nxt_st.ctl.vco_full_sweep = 1'b0;
      end
      default: begin
        nxt_st.ctl.vco_center_on_ref = 1'b0;
        nxt_st.ctl.vco_full_sweep = 1'b0;
      end
    endcase

    // Receiver controls
    nxt_st.ctl.jitter_bw_select = nxt_st.cmu[7:4];
    nxt_st.ctl.jitter_bw_supported = (nxt_st.cmu[7:4] == `RXAI_BW_380K);
    nxt_st.ctl.lock_to_ref = ltr_act;
    nxt_st.ctl.keep_data_lock_attempt = ltr_act & nxt_st.lock[`RXAI_LK_KEEP_DATA];
    nxt_st.ctl.unlock_uses_quality = use_q;
    nxt_st.ctl.cmu_ref_lock = nxt_st.lock[`RXAI_LK_CMU_REF];
    nxt_st.ctl.receive_reference_present = nxt_st.lock[`RXAI_LK_REF_PRESENT];
    nxt_st.ctl.loss_of_lock = nxt_st.alarm[4];
    nxt_st.ctl.loss_of_signal = los;

    // Interrupt gating
    nxt_st.irq = nxt_st.gie & (|(nxt_st.sticky & ~nxt_st.mask));

    // Read data captured in the setup phase
    case (paddr[7:2])
      `RXAI_IDX_CHIP: rd = {2'h0, st.gie, 5'h00};
      `RXAI_IDX_MASK: rd = {1'b0, st.mask};
      `RXAI_IDX_STICKY: rd = {1'b0, st.sticky};
      `RXAI_IDX_CMU: rd = st.cmu;
      `RXAI_IDX_LOCK: rd = {1'b0, st.lock[6:3], st.ctl.unlock_uses_quality, st.lock[1:0]};
      `RXAI_IDX_CAL: rd = {4'h0, (st.cal == RXAI_CAL_BUSY), st.vco, st.sw_rst};
      `RXAI_IDX_ALARM: rd = {1'b0, st.alarm};
      `RXAI_IDX_LOSC: rd = {4'h0, st.losc};
      default: rd = 8'h00;
    endcase
    nxt_st.pslverr = 1'b0;
    if (setup) begin
      nxt_st.prdata = {24'h000000, (mapped ? rd : 8'h00)};
      nxt_st.pslverr = ~mapped;
    end else if (psel) begin
      nxt_st.pslverr = st.pslverr;
    end
  end

  // State register with synchronous reset
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      st <= '0;
      st.cmu <= `RXAI_RST_CMU;
      st.lock <= `RXAI_RST_LOCK;
      st.mask <= `RXAI_RST_MASK;
      st.losc <= `RXAI_RST_LOSC;
      st.vco <= `RXAI_RST_VCO;
    end else begin
      st <= nxt_st;
    end
  end

  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  a_sticky_latch_set:
    assert property ((st.gie && !st.sw_rst && st.alarm != 7'h00)
      |=> ((st.sticky & $past(st.alarm)) == $past(st.alarm) || !st.gie))
    else $error("sticky bit missed a live alarm");

  a_irq_needs_enable:
    assert property (irq_out |-> st.gie)
    else $error("interrupt without global enable");

  a_irq_masked_quiet:
    assert property (((st.sticky & ~st.mask) == 7'h00) |-> !irq_out)
    else $error("masked alarm drove the interrupt");

  a_irq_raise:
    assert property ((st.gie && (st.sticky & ~st.mask) != 7'h00) |-> irq_out)
    else $error("unmasked sticky bit without interrupt");

  a_sticky_off_clear:
    assert property (!st.gie |-> st.sticky == 7'h00)
    else $error("sticky bits kept while disabled");

  a_los_or_gated:
    assert property (st.alarm[`RXAI_AL_LOS] ==
      ((st.losc[0] & st.filt.analog_loss) | (st.losc[1] & st.filt.run_zeros)
       | (st.losc[2] & st.filt.run_ones) | (st.losc[3] & st.filt.quality_loss)))
    else $error("loss alarm not the gated OR");

  a_unsync_when_off:
    assert property (!pattern_checker_enabled |=> !st.alarm[`RXAI_AL_UNSYNC])
    else $error("unsync alarm with checker off");

  a_vco_bad_unlock:
    assert property ((st.vco == `RXAI_VCO_BAD) |-> st.ctl.loss_of_lock)
    else $error("invalid vco mode without unlock");

  a_unlock_on_loss:
    assert property ((st.lock[`RXAI_LK_UNLOCK_ON_LOS] && st.alarm[`RXAI_AL_LOS])
      |-> st.alarm[`RXAI_AL_LOL])
    else $error("no unlock on signal loss");

  a_soft_reset_done:
    assert property (st.sw_rst |=> (!st.sw_rst && st.mask == `RXAI_RST_MASK
      && st.cmu == `RXAI_RST_CMU && st.losc == `RXAI_RST_LOSC))
    else $error("soft reset did not restore defaults");

  a_recal_self_clear:
    assert property ((st.cal == RXAI_CAL_BUSY && !st.filt.cal_done && st.s2.cal_done
      && st.s3.cal_done) |=> st.cal == RXAI_CAL_IDLE)
    else $error("recalibrate bit not cleared on done");

  a_sticky_from_alarm:
    assert property ((st.sticky & ~$past(st.sticky) & ~$past(st.alarm)) == 7'h00)
    else $error("sticky bit set without a live alarm");

  a_sticky_write_zero:
    assert property ((psel && penable && pwrite && rxai_hit(paddr, `RXAI_IDX_STICKY))
      |=> ((st.sticky & ~$past(pwdata[6:0]) & ~$past(st.alarm)) == 7'h00))
    else $error("sticky bit survived a write of zero");

  a_bw_code_flag:
    assert property ($past(reset_n) |-> (st.ctl.jitter_bw_supported
      == (st.cmu[7:4] == `RXAI_BW_380K)))
    else $error("bandwidth support flag wrong");

  a_ref_lock_loss:
    assert property ((st.lock[`RXAI_LK_REF_ON_LOS] && st.alarm[`RXAI_AL_LOS])
      |-> st.ctl.lock_to_ref)
    else $error("no reference lock on signal loss");

  a_keep_data_sel:
    assert property (st.ctl.keep_data_lock_attempt
      == (st.ctl.lock_to_ref && st.lock[`RXAI_LK_KEEP_DATA]))
    else $error("data lock attempt select wrong");

  a_unlock_mode_ovr:
    assert property (st.lock[`RXAI_LK_MODE_OVR]
      |-> (st.ctl.unlock_uses_quality == st.lock[`RXAI_LK_MODE_SEL]))
    else $error("override unlock mode not followed");

  a_unlock_mode_auto:
    assert property (($past(reset_n) && !st.lock[`RXAI_LK_MODE_OVR])
      |-> (st.ctl.unlock_uses_quality == !st.ctl.lock_to_ref))
    else $error("automatic unlock mode wrong");

  a_ref_lock_bits:
    assert property ((st.ctl.cmu_ref_lock == st.lock[`RXAI_LK_CMU_REF])
      && (st.ctl.receive_reference_present == st.lock[`RXAI_LK_REF_PRESENT]))
    else $error("reference lock bits not driven");

  a_recal_pulse_busy:
    assert property (st.ctl.recal_start |-> (st.cal == RXAI_CAL_BUSY))
    else $error("calibration start while not busy");

  a_vco_auto_pick:
    assert property (($past(reset_n) && st.vco == `RXAI_VCO_AUTO) |->
      ((st.ctl.vco_center_on_ref == (!st.filt.ref_missing && st.lock[`RXAI_LK_REF_PRESENT]))
      && (st.ctl.vco_full_sweep != st.ctl.vco_center_on_ref)))
    else $error("automatic vco mode wrong");

  a_vco_sweep_mode:
    assert property ((st.vco == `RXAI_VCO_NOREF)
      |-> (st.ctl.vco_full_sweep && !st.ctl.vco_center_on_ref))
    else $error("sweep vco mode wrong");

  a_vco_ref_mode:
    assert property ((st.vco == `RXAI_VCO_REF)
      |-> (st.ctl.vco_center_on_ref && !st.ctl.vco_full_sweep))
    else $error("reference vco mode wrong");

  a_ref_missing_bit:
    assert property (st.alarm[6] == st.filt.ref_missing)
    else $error("reference missing alarm wrong");

  a_pattern_limit_bit:
    assert property (st.alarm[2] == st.filt.pat_err_limit)
    else $error("pattern error alarm wrong");

  a_fifo_auto_pulse:
    assert property ((st.alarm[3] && $past(fifo_self_recover) && $past(fifo_self_recover, 2))
      |-> !$past(st.alarm[3]))
    else $error("fifo alarm held under self recovery");

endmodule

// ---- logic/rxai_consts.svh ----
`ifndef RXAI_CONSTS_SVH
`define RXAI_CONSTS_SVH
// Register indices; byte address is four times the index
`define RXAI_IDX_CHIP 6'h02
`define RXAI_IDX_MASK 6'h04
`define RXAI_IDX_STICKY 6'h05
`define RXAI_IDX_CMU 6'h06
`define RXAI_IDX_LOCK 6'h07
`define RXAI_IDX_CAL 6'h08
`define RXAI_IDX_ALARM 6'h09
`define RXAI_IDX_LOSC 6'h0a
// Field positions
`define RXAI_GIE_BIT 5
`define RXAI_LK_UNLOCK_ON_LOS 6
`define RXAI_LK_REF_ON_LOS 5
`define RXAI_LK_KEEP_DATA 4
`define RXAI_LK_MODE_OVR 3
`define RXAI_LK_MODE_SEL 2
`define RXAI_LK_CMU_REF 1
`define RXAI_LK_REF_PRESENT 0
`define RXAI_CAL_RECAL 3
`define RXAI_CAL_SWRST 0
`define RXAI_LC_QUAL_EN 3
`define RXAI_LC_ONES 2
`define RXAI_LC_ZEROS 1
`define RXAI_LC_ANALOG_EN 0
`define RXAI_AL_LOS 5
`define RXAI_AL_LOL 4
`define RXAI_AL_UNSYNC 1
// Reset values
`define RXAI_RST_CMU 8'h40
`define RXAI_RST_LOCK 7'h00
`define RXAI_RST_MASK 7'h00
`define RXAI_RST_LOSC 4'h0
`define RXAI_RST_VCO 2'h0
// Codes
`define RXAI_BW_380K 4'h4
`define RXAI_VCO_AUTO 2'h0
`define RXAI_VCO_NOREF 2'h1
`define RXAI_VCO_REF 2'h2
`define RXAI_VCO_BAD 2'h3
`endif

// ---- logic/rxai_pkg.sv ----
package rxai_pkg;
  // Detector levels from the analog and data-path side
  typedef struct packed {
    logic cal_done;         // Calibration engine finished
    logic ref_missing;      // Reference clock frequency far off
    logic analog_loss;      // Analog loss of signal
    logic run_zeros;        // Zero run reached threshold
    logic run_ones;         // One run reached threshold
    logic quality_loss;     // Signal quality loss
    logic freq_unlock;      // Frequency-compare unlock
    logic sqm_unlock;       // Quality-based unlock
    logic fifo_fault;       // FIFO over or underflow
    logic pat_err_limit;    // Checker hit target error count
    logic pat_unsynced;     // Checker lost pattern sync
    logic sqm_alarm;        // Quality monitor met threshold
  } rxai_det_s;
  // Controls driven to the receiver
  typedef struct packed {
    logic [3:0] jitter_bw_select;   // CMU bandwidth code
    logic jitter_bw_supported;      // Code is the one supported value
    logic lock_to_ref;              // Lock-to-reference active
    logic keep_data_lock_attempt;   // CDR keeps trying data lock
    logic unlock_uses_quality;      // Unlock judged by quality
    logic cmu_ref_lock;             // CMU locked to reference
    logic receive_reference_present; // Reference applied
    logic vco_center_on_ref;        // Centre VCO on reference
    logic vco_full_sweep;           // Sweep whole VCO range
    logic recal_start;              // One-cycle calibration start
    logic loss_of_lock;             // Receive loss of lock
    logic loss_of_signal;           // Receive loss of signal
  } rxai_ctl_s;
  // Calibration sequencer
  typedef enum logic [0:0] {
    RXAI_CAL_IDLE = 1'b0,
    RXAI_CAL_BUSY = 1'b1
  } rxai_cal_e;
  // Whole module state
  typedef struct packed {
    rxai_det_s s1;
    rxai_det_s s2;
    rxai_det_s s3;
    rxai_det_s filt;
    logic gie;
    logic [6:0] mask;
    logic [6:0] sticky;
    logic [7:0] cmu;
    logic [6:0] lock;
    rxai_cal_e cal;
    logic [1:0] vco;
    logic sw_rst;
    logic [3:0] losc;
    logic [6:0] alarm;
    rxai_ctl_s ctl;
    logic irq;
    logic [31:0] prdata;
    logic pslverr;
  } rxai_state_s;
endpackage

// ---- verification/rxai_host.sv ----
`timescale 1ns/1ps
// Host controller model: drives APB transfers into the register block
module rxai_host (
  input wire logic ref_clk,        // Bus clock
  output logic psel,               // Select
  output logic penable,            // Access phase
  output logic pwrite,             // Direction
  output logic [7:0] paddr,        // Byte address
  output logic [31:0] pwdata,      // Write data
  input wire logic [31:0] prdata,  // Read data
  input wire logic pready,         // Ready
  input wire logic pslverr         // Error
);
  // Idle bus from time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end
  // One transfer; request held until ready is seen at a rising edge
  // The index is six bits wide, so every word address of the block can be hit
  task automatic xfer(input logic w, input logic [5:0] idx, input logic [7:0] d,
                      output logic [7:0] q, output logic e);
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge ref_clk);
    penable <= 1'b1;
    // Hold the access phase until ready is seen high at a rising edge
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    // Answer taken at that same edge, before the slave updates
    q = prdata[7:0];
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule

// ---- verification/rx_alarm_interrupt_control_tb_top.sv ----
`timescale 1ns/1ps
`include "rxai_consts.svh"
module rx_alarm_interrupt_control_tb_top;
  import rxai_pkg::*;
  logic ref_clk = 1'b0;             // 20 MHz clock
  logic reset_n = 1'b0;             // Held low at start
  logic psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;                // Bus address
  logic [31:0] pwdata, prdata;      // Bus data
  rxai_det_s det = '0;              // Detector levels
  logic fifo_self_recover = 1'b0;   // FIFO auto reset
  logic pattern_checker_enabled = 1'b0;
  rxai_ctl_s ctl;                   // Receiver controls
  logic irq;                        // Interrupt
  int fail_count = 0;
  int checks = 0;
  int cyc = 0;                      // Cycle counter for timeout
  int pulses = 0;                   // Calibration start pulses
  logic [7:0] q;                    // Last read byte
  logic e;                          // Last error flag
  always #25 ref_clk = ~ref_clk;
  rxai_top i_rxai_top (.ref_clk(ref_clk), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .det_in(det),
    .fifo_self_recover(fifo_self_recover),
    .pattern_checker_enabled(pattern_checker_enabled), .ctl_out(ctl), .irq_out(irq));
  rxai_host i_rxai_host (.ref_clk(ref_clk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  // Compare and count
  task automatic chk(input logic [31:0] s, input logic [31:0] x, input string m);
    checks++;
    if (s !== x) begin
      fail_count++;
      $display("mismatch t=%0t %s seen=%h exp=%h", $time, m, s, x);
    end
  endtask
  task automatic wr(input logic [5:0] i, input logic [7:0] d);
    i_rxai_host.xfer(1'b1, i, d, q, e);
  endtask
  task automatic rd(input logic [5:0] i);
    i_rxai_host.xfer(1'b0, i, 8'h00, q, e);
  endtask
  // Change detectors, then let the input filter settle
  task automatic setd(input rxai_det_s v);
    @(posedge ref_clk);
    det <= v;
    repeat (5) @(posedge ref_clk);
  endtask
  function automatic logic los_exp(input logic [3:0] c, input rxai_det_s d);
    return (c[0] & d.analog_loss) | (c[1] & d.run_zeros) | (c[2] & d.run_ones)
      | (c[3] & d.quality_loss);
  endfunction
  function automatic logic uq_exp(input logic [3:0] l);
    return l[3] ? l[2] : ~l[1];
  endfunction
  task tally_and_finish;
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Hang guard and pulse counter
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (ctl.recal_start === 1'b1) pulses <= pulses + 1;
    if (cyc == 20000) begin
      fail_count++;
      tally_and_finish();
    end
  end
  initial begin
    logic [7:0] m;
    rxai_det_s d;
    void'($urandom(14));
    repeat (3) @(posedge ref_clk);
    reset_n <= 1'b1;
    // Reset values, unmapped access, bandwidth code
    rd(`RXAI_IDX_CMU);
    chk(q, `RXAI_RST_CMU, "cmu reset");
    chk(e, 1'b0, "mapped");
    chk(ctl.jitter_bw_select, `RXAI_BW_380K, "bw code");
    chk(ctl.jitter_bw_supported, 1'b1, "bw ok");
    rd(6'h03);
    chk(e, 1'b1, "unmapped");
    wr(`RXAI_IDX_CMU, 8'h50);
    rd(`RXAI_IDX_CMU);
    chk(ctl.jitter_bw_supported, 1'b0, "bw bad");
    wr(`RXAI_IDX_CMU, 8'h40);
    $display("test reset_map done");
    // Every loss enable combination against random detectors
    for (int i = 0; i < 16; i++) begin
      d = rxai_det_s'($urandom);
      d.cal_done = 1'b0;
      wr(`RXAI_IDX_LOSC, i[7:0]);
      setd(d);
      rd(`RXAI_IDX_ALARM);
      chk(q[5], los_exp(i[3:0], d), "los bit");
      chk(ctl.loss_of_signal, los_exp(i[3:0], d), "los out");
      chk(q[6], d.ref_missing, "ref bit");
      chk(q[0], d.sqm_alarm, "sqm bit");
      chk(q[2], d.pat_err_limit, "pat err");
      chk(q[3], d.fifo_fault, "fifo");
      chk(q[1], 1'b0, "unsync off");
      chk(irq, 1'b0, "irq off");
    end
    $display("test signal_loss done");
    // Sticky latch, masking, clearing for each alarm
    setd('0);
    wr(`RXAI_IDX_LOSC, 8'h01);
    pattern_checker_enabled <= 1'b1;
    wr(`RXAI_IDX_CHIP, 8'h20);
    for (int b = 0; b < 7; b++) begin
      m = 8'($urandom) & 8'h7f;
      wr(`RXAI_IDX_MASK, m);
      d = '0;
      case (b)
        0: d.sqm_alarm = 1'b1;
        1: d.pat_unsynced = 1'b1;
        2: d.pat_err_limit = 1'b1;
        3: d.fifo_fault = 1'b1;
        4: d.sqm_unlock = 1'b1;
        5: d.analog_loss = 1'b1;
        default: d.ref_missing = 1'b1;
      endcase
      setd(d);
      setd('0);
      rd(`RXAI_IDX_STICKY);
      chk(q, 8'h01 << b, "sticky");
      chk(irq, |((8'h01 << b) & ~m), "irq");
      wr(`RXAI_IDX_STICKY, 8'h00);
      rd(`RXAI_IDX_STICKY);
      chk(q, 8'h00, "clear");
    end
    wr(`RXAI_IDX_MASK, 8'h00);
    setd(d);
    wr(`RXAI_IDX_CHIP, 8'h00);
    rd(`RXAI_IDX_STICKY);
    chk(q, 8'h00, "gie clear");
    chk(irq, 1'b0, "gie irq");
    setd('0);
    $display("test sticky done");
    // Lock mode selection
    for (int j = 0; j < 16; j++) begin
      wr(`RXAI_IDX_LOCK, j[7:0]);
      rd(`RXAI_IDX_LOCK);
      chk(ctl.unlock_uses_quality, uq_exp(j[3:0]), "lol mode");
      chk(q[2], uq_exp(j[3:0]), "lol read");
      chk(ctl.cmu_ref_lock, j[1], "cmu ref");
    end
    wr(`RXAI_IDX_LOCK, 8'h70);
    d = '0;
    d.analog_loss = 1'b1;
    setd(d);
    chk(ctl.loss_of_lock, 1'b1, "lol on los");
    chk(ctl.lock_to_ref, 1'b1, "ltr on los");
    chk(ctl.keep_data_lock_attempt, 1'b1, "keep data");
    setd('0);
    $display("test lock done");
    // VCO modes with and without reference
    for (int k = 0; k < 8; k++) begin
      wr(`RXAI_IDX_LOCK, {7'h0, k[0]});
      wr(`RXAI_IDX_CAL, {5'h0, k[2:1], 1'b0});
      rd(`RXAI_IDX_CAL);
      chk(ctl.loss_of_lock, k[2:1] == 2'h3, "vco bad");
      chk(ctl.receive_reference_present, k[0], "ref en");
      if (k[2:1] != 2'h3) begin
        chk(ctl.vco_center_on_ref, k[2:1] == 2'h2 || (k[2:1] == 2'h0 && k[0]), "ctr");
        chk(ctl.vco_full_sweep, k[2:1] == 2'h1 || (k[2:1] == 2'h0 && !k[0]), "swp");
      end
    end
    $display("test vco done");
    // Recalibration, FIFO self recovery, soft reset
    wr(`RXAI_IDX_CAL, 8'h08);
    rd(`RXAI_IDX_CAL);
    chk(q[3], 1'b1, "recal set");
    d = '0;
    d.cal_done = 1'b1;
    setd(d);
    rd(`RXAI_IDX_CAL);
    chk(q[3], 1'b0, "recal done");
    chk(pulses, 1, "recal pulse");
    fifo_self_recover <= 1'b1;
    d.fifo_fault = 1'b1;
    setd(d);
    rd(`RXAI_IDX_ALARM);
    chk(q[3], 1'b0, "fifo auto");
    wr(`RXAI_IDX_MASK, 8'h55);
    wr(`RXAI_IDX_CMU, 8'h30);
    wr(`RXAI_IDX_CAL, 8'h01);
    repeat (3) @(posedge ref_clk);
    rd(`RXAI_IDX_MASK);
    chk(q, 8'h00, "swrst mask");
    rd(`RXAI_IDX_CMU);
    chk(q, `RXAI_RST_CMU, "swrst cmu");
    rd(`RXAI_IDX_CAL);
    chk(q, 8'h00, "swrst self");
    $display("test cal done");
    tally_and_finish();
  end
endmodule
